/* shared/scrb_pkg.sv */
`default_nettype none
package scrb_pkg;

  // ------------------------------------------------------------
  // Register bank layout
  // ------------------------------------------------------------
  localparam int NUM_REGS = 14;
  localparam int NUM_CH = 3;
  localparam int REGS_PER_CH = 3;
  localparam int OFS_CLAMP = 0;
  localparam int OFS_COARSE = 1;
  localparam int OFS_FINE = 2;
  localparam logic [3:0] IDX_CTRL = 4'h9;
  localparam logic [3:0] IDX_VCO = 4'hA;
  localparam logic [3:0] IDX_DIV = 4'hB;
  localparam logic [3:0] IDX_PHA = 4'hC;
  localparam logic [3:0] IDX_PHB = 4'hD;
  localparam logic [3:0] IDX_LAST = 4'hD;
  localparam logic [3:0] IDX_FIRST = 4'h0;

  // Reset values, index 13 first, index 0 last
  localparam logic [13:0][7:0] CFG_RESET = {
    8'h00, 8'h00, 8'h90, 8'h61, 8'h04,
    8'h00, 8'h20, 8'h7F,
    8'h00, 8'h20, 8'h7F,
    8'h00, 8'h20, 8'h7F
  };
  localparam logic [11:0] RATIO_RESET = 12'h320;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int COARSE_W = 7;
  localparam int FINE_W = 5;
  localparam int CTRL_FRAME_INV = 7;
  localparam int CTRL_LINE_INV = 6;
  localparam int CTRL_EDGE = 5;
  localparam int CTRL_UP = 4;
  localparam int CTRL_DN = 3;
  localparam int CTRL_IP_LSB = 0;
  localparam int VCO_Z_LSB = 5;
  localparam int VCO_GAIN_LSB = 3;
  localparam int VCO_DIHI_LSB = 0;
  localparam int PH_DI0 = 6;
  localparam int PH_CK = 5;
  localparam int PH_STEP_LSB = 0;
  localparam int PH_STEP_W = 5;

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  localparam logic [4:0] DEV_ADDR_HI = 5'h13;
  localparam int SUB_SEQ_BIT = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_ID1 = 2;
  localparam int PIN_ID2 = 3;
  localparam int PIN_OFF = 4;
  localparam logic [4:0] PIN_RESET = 5'h03;
  localparam int SYNC_HOLD = 0;
  localparam int SYNC_LINE = 1;
  localparam int SYNC_REF = 2;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_ACK, ST_IGNORE} scrb_state_e;

endpackage
`default_nettype wire

/* src/scrb_top.sv */
// Contract
// R01 - Clamp code 127 means zero, reset 127
// R02 - Coarse gain code, default 32
// R03 - Fine gain code 0..31, default 0
// R04 - Polarity bits invert hold and sync inputs
// R05 - Edge bit picks reference clock edge
// R06 - Host keeps pump test bits zero
// R07 - Pump current code, default 100 uA
// R08 - Loop filter resistor code select
// R09 - Oscillator gain code select
// R10 - Twelve bit divider, default 800
// R11 - Host writes high bits, bit0 first
// R12 - Divider bit0 marks odd ratio
// R13 - Sequential load twice when bit0 changes
// R14 - Power loss restores all defaults
// R15 - Power-down keeps register contents
// R16 - Clock source bit, default PLL
// R17 - Second clock enable, default off
// R18 - Phase steps of 11.25 degrees, reset zero
// R19 - Answer address 10011 plus id pins
// R20 - Write only, direction bit zero
// R21 - Single mode: sub-address/data pairs acked
// R22 - Sequential mode via sub-address xxx1 1111
// R23 - Sub-address bit4 mode, bits3..0 index
// R24 - Sequential bytes fill indexes 0 to 13
// R25 - Port off pin ignores bus
// R26 - No ack on foreign address or read
`timescale 1ns/1ps
`default_nettype none
module scrb_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic adc_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen_o,
  input wire logic bus_id_pin_1_i,
  input wire logic bus_id_pin_2_i,
  input wire logic serial_port_off_pin_i,
  input wire logic pll_hold_input_i,
  input wire logic line_sync_input_i,
  input wire logic line_reference_clock_i,
  output logic pll_hold_o,
  output logic line_sync_o,
  output logic ref_edge_o,
  output logic [2:0][7:0] clamp_level_o,
  output logic [2:0][6:0] gain_coarse_o,
  output logic [2:0][4:0] gain_fine_o,
  output logic pump_force_raise_o,
  output logic pump_force_lower_o,
  output logic [2:0] pump_current_select_o,
  output logic [2:0] loop_filter_resistor_select_o,
  output logic [1:0] osc_gain_select_o,
  output logic [11:0] pll_ratio_bits_o,
  output logic adc_clock_source_o,
  output logic second_clock_enable_o,
  output logic [4:0] phase_a_step_o,
  output logic [4:0] phase_b_step_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Filtered level follows when second and third stages agree
  function automatic logic [4:0] agree5(input logic [4:0] s2, input logic [4:0] s3, input logic [4:0] old);
    agree5 = (s2 & s3) | (old & (s2 ^ s3));
  endfunction

  // ------------------------------------------------------------
  // Pin sampling, system clock
  // ------------------------------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic [4:0] pin_f_q;
  logic [4:0] pin_prev_q;

  assign pin_raw = {serial_port_off_pin_i, bus_id_pin_2_i, bus_id_pin_1_i, sda_i, scl_i};

  // Three stage sampling with agreement filter
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pin_s1_q <= scrb_pkg::PIN_RESET;
      pin_s2_q <= scrb_pkg::PIN_RESET;
      pin_s3_q <= scrb_pkg::PIN_RESET;
      pin_f_q <= scrb_pkg::PIN_RESET;
      pin_prev_q <= scrb_pkg::PIN_RESET;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= agree5(pin_s2_q, pin_s3_q, pin_f_q);
      pin_prev_q <= pin_f_q;
    end
  end

  // Bus conditions
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic port_off;
  logic [6:0] own_addr;

  assign scl_rise = pin_f_q[scrb_pkg::PIN_SCL] & ~pin_prev_q[scrb_pkg::PIN_SCL];
  assign scl_fall = ~pin_f_q[scrb_pkg::PIN_SCL] & pin_prev_q[scrb_pkg::PIN_SCL];
  assign bus_start = pin_f_q[scrb_pkg::PIN_SCL] & pin_prev_q[scrb_pkg::PIN_SCL]
                     & pin_prev_q[scrb_pkg::PIN_SDA] & ~pin_f_q[scrb_pkg::PIN_SDA];
  assign bus_stop = pin_f_q[scrb_pkg::PIN_SCL] & pin_prev_q[scrb_pkg::PIN_SCL]
                    & ~pin_prev_q[scrb_pkg::PIN_SDA] & pin_f_q[scrb_pkg::PIN_SDA];
  assign port_off = pin_f_q[scrb_pkg::PIN_OFF];
  assign own_addr = {scrb_pkg::DEV_ADDR_HI, pin_f_q[scrb_pkg::PIN_ID2], pin_f_q[scrb_pkg::PIN_ID1]}; // R19

  // ------------------------------------------------------------
  // Serial slave engine
  // ------------------------------------------------------------
  scrb_pkg::scrb_state_e state_q;
  scrb_pkg::scrb_state_e next_q;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic [3:0] idx_q;
  logic seq_q;
  logic byte_end;
  logic addr_hit;
  logic wr_en;

  assign byte_end = scl_fall && (cnt_q == scrb_pkg::BITS_PER_BYTE);
  assign addr_hit = (shreg_q[7:1] == own_addr) && !shreg_q[0]; // R20 R26
  assign wr_en = (state_q == scrb_pkg::ST_DATA) && byte_end && (idx_q <= scrb_pkg::IDX_LAST);

  // Byte framing, acknowledge and sub-address handling
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= scrb_pkg::ST_IDLE;
      next_q <= scrb_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      idx_q <= 4'h0;
      seq_q <= 1'b0;
      sda_oen_o <= 1'b1;
      sda_o <= 1'b0;
    end
    else if (port_off || bus_stop)
    begin
      state_q <= scrb_pkg::ST_IDLE; // R25
      sda_oen_o <= 1'b1;
    end
    else if (bus_start)
    begin
      state_q <= scrb_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      sda_oen_o <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        scrb_pkg::ST_IDLE, scrb_pkg::ST_IGNORE:
        begin
          sda_oen_o <= 1'b1;
        end
        scrb_pkg::ST_ADDR, scrb_pkg::ST_SUB, scrb_pkg::ST_DATA:
        begin
          if (scl_rise)
          begin
            shreg_q <= {shreg_q[6:0], pin_f_q[scrb_pkg::PIN_SDA]};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_q <= 4'h0;
            if (state_q == scrb_pkg::ST_ADDR)
            begin
              if (addr_hit)
              begin
                state_q <= scrb_pkg::ST_ACK;
                next_q <= scrb_pkg::ST_SUB;
                sda_oen_o <= 1'b0; // R19
              end
              else
              begin
                state_q <= scrb_pkg::ST_IGNORE; // R26
              end
            end
            else if (state_q == scrb_pkg::ST_SUB)
            begin
              seq_q <= shreg_q[scrb_pkg::SUB_SEQ_BIT]; // R23
              idx_q <= shreg_q[scrb_pkg::SUB_SEQ_BIT] ? scrb_pkg::IDX_FIRST : shreg_q[3:0]; // R22 R23
              state_q <= scrb_pkg::ST_ACK;
              next_q <= scrb_pkg::ST_DATA;
              sda_oen_o <= 1'b0;
            end
            else
            begin
              state_q <= scrb_pkg::ST_ACK;
              next_q <= seq_q ? scrb_pkg::ST_DATA : scrb_pkg::ST_SUB; // R21 R22
              sda_oen_o <= 1'b0;
              if (seq_q && (idx_q <= scrb_pkg::IDX_LAST))
              begin
                idx_q <= idx_q + 4'h1; // R24
              end
            end
          end
        end
        scrb_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            sda_oen_o <= 1'b1;
            state_q <= next_q;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------
  logic [13:0][7:0] cfg_q;
  logic [11:0] ratio_q;

  // Only rstn_i (power-on) clears; power-down has no path here
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_q <= scrb_pkg::CFG_RESET; // R01 R02 R03 R14
      ratio_q <= scrb_pkg::RATIO_RESET; // R10
    end
    else if (wr_en)
    begin
      cfg_q[idx_q] <= shreg_q; // R15
      if (idx_q == scrb_pkg::IDX_DIV)
      begin
        // Low byte write commits the ratio with stored high bits and parity
        ratio_q <= {cfg_q[scrb_pkg::IDX_VCO][scrb_pkg::VCO_DIHI_LSB +: 3], shreg_q,
                    cfg_q[scrb_pkg::IDX_PHA][scrb_pkg::PH_DI0]}; // R11 R12 R13
      end
    end
  end

  // ------------------------------------------------------------
  // Crossing to converter clock, toggle handshake
  // ------------------------------------------------------------
  logic dirty_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic launch;
  logic [13:0][7:0] xfer_cfg_q;
  logic [11:0] xfer_ratio_q;
  logic seen_q;

  assign launch = dirty_q && (req_q == ack_s2_q);

  // Snapshot held stable until the far side has taken it
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      dirty_q <= 1'b0;
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      xfer_cfg_q <= scrb_pkg::CFG_RESET;
      xfer_ratio_q <= scrb_pkg::RATIO_RESET;
    end
    else
    begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
      if (wr_en)
      begin
        dirty_q <= 1'b1; // New write wins over launch clear
      end
      else if (launch)
      begin
        dirty_q <= 1'b0;
      end
      if (launch)
      begin
        xfer_cfg_q <= cfg_q;
        xfer_ratio_q <= ratio_q;
        req_q <= ~req_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Converter clock domain
  // ------------------------------------------------------------
  logic adc_rst_s1_q;
  logic adc_rstn_q;
  logic req_s1_q;
  logic req_s2_q;
  logic [13:0][7:0] adc_cfg_q;
  logic [11:0] adc_ratio_q;

  // Reset release brought onto the converter clock
  always_ff @(posedge adc_clk_i)
  begin
    adc_rst_s1_q <= rstn_i;
    adc_rstn_q <= adc_rst_s1_q;
  end

  // Capture the snapshot once the request toggle lands
  always_ff @(posedge adc_clk_i)
  begin
    if (!adc_rstn_q)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      seen_q <= 1'b0;
      adc_cfg_q <= scrb_pkg::CFG_RESET;
      adc_ratio_q <= scrb_pkg::RATIO_RESET;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      seen_q <= req_s2_q;
      if (req_s2_q != seen_q)
      begin
        adc_cfg_q <= xfer_cfg_q;
        adc_ratio_q <= xfer_ratio_q;
      end
    end
  end

  // Sync pins sampled on the converter clock
  logic [4:0] sy_raw;
  logic [4:0] sy_s1_q;
  logic [4:0] sy_s2_q;
  logic [4:0] sy_s3_q;
  logic [4:0] sy_f_q;
  logic ref_prev_q;
  logic [7:0] ctrl;

  assign sy_raw = {2'b00, line_reference_clock_i, line_sync_input_i, pll_hold_input_i};
  assign ctrl = adc_cfg_q[scrb_pkg::IDX_CTRL];

  always_ff @(posedge adc_clk_i)
  begin
    if (!adc_rstn_q)
    begin
      sy_s1_q <= 5'h00;
      sy_s2_q <= 5'h00;
      sy_s3_q <= 5'h00;
      sy_f_q <= 5'h00;
      ref_prev_q <= 1'b0;
      pll_hold_o <= 1'b0;
      line_sync_o <= 1'b0;
      ref_edge_o <= 1'b0;
    end
    else
    begin
      sy_s1_q <= sy_raw;
      sy_s2_q <= sy_s1_q;
      sy_s3_q <= sy_s2_q;
      sy_f_q <= agree5(sy_s2_q, sy_s3_q, sy_f_q);
      ref_prev_q <= sy_f_q[scrb_pkg::SYNC_REF];
      pll_hold_o <= sy_f_q[scrb_pkg::SYNC_HOLD] ^ ctrl[scrb_pkg::CTRL_FRAME_INV]; // R04
      line_sync_o <= sy_f_q[scrb_pkg::SYNC_LINE] ^ ctrl[scrb_pkg::CTRL_LINE_INV]; // R04
      // Pulse on the selected reference edge
      ref_edge_o <= ctrl[scrb_pkg::CTRL_EDGE] ? (ref_prev_q & ~sy_f_q[scrb_pkg::SYNC_REF])
                                             : (~ref_prev_q & sy_f_q[scrb_pkg::SYNC_REF]); // R05
    end
  end

  // ------------------------------------------------------------
  // Setting outputs, straight from the converter-side copy
  // ------------------------------------------------------------
  // Per-channel clamp and gain codes
  for (genvar ch = 0; ch < scrb_pkg::NUM_CH; ch++)
  begin : g_ch
    assign clamp_level_o[ch] = adc_cfg_q[ch * scrb_pkg::REGS_PER_CH + scrb_pkg::OFS_CLAMP]; // R01
    assign gain_coarse_o[ch] =
      adc_cfg_q[ch * scrb_pkg::REGS_PER_CH + scrb_pkg::OFS_COARSE][scrb_pkg::COARSE_W-1:0]; // R02
    assign gain_fine_o[ch] =
      adc_cfg_q[ch * scrb_pkg::REGS_PER_CH + scrb_pkg::OFS_FINE][scrb_pkg::FINE_W-1:0]; // R03
  end

  // PLL and clock selection fields
  assign pump_force_raise_o = ctrl[scrb_pkg::CTRL_UP]; // R06
  assign pump_force_lower_o = ctrl[scrb_pkg::CTRL_DN]; // R06
  assign pump_current_select_o = ctrl[scrb_pkg::CTRL_IP_LSB +: 3]; // R07
  assign loop_filter_resistor_select_o = adc_cfg_q[scrb_pkg::IDX_VCO][scrb_pkg::VCO_Z_LSB +: 3]; // R08
  assign osc_gain_select_o = adc_cfg_q[scrb_pkg::IDX_VCO][scrb_pkg::VCO_GAIN_LSB +: 2]; // R09
  assign pll_ratio_bits_o = adc_ratio_q; // R10 R12
  assign adc_clock_source_o = adc_cfg_q[scrb_pkg::IDX_PHA][scrb_pkg::PH_CK]; // R16
  assign second_clock_enable_o = adc_cfg_q[scrb_pkg::IDX_PHB][scrb_pkg::PH_CK]; // R17
  assign phase_a_step_o = adc_cfg_q[scrb_pkg::IDX_PHA][scrb_pkg::PH_STEP_LSB +: scrb_pkg::PH_STEP_W]; // R18
  assign phase_b_step_o = adc_cfg_q[scrb_pkg::IDX_PHB][scrb_pkg::PH_STEP_LSB +: scrb_pkg::PH_STEP_W]; // R18

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  reset_default_a: assert property (@(posedge clk_i) !rstn_i |=> // R01
    (cfg_q == scrb_pkg::CFG_RESET) && (ratio_q == 12'h320))
    else $error("Registers not at defaults after reset");

  port_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R25
    port_off |=> sda_oen_o && (state_q == scrb_pkg::ST_IDLE))
    else $error("Port disabled but engine active");

  read_nack_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R26
    (state_q == scrb_pkg::ST_ADDR) && byte_end && shreg_q[0] && !port_off && !bus_stop && !bus_start
    |=> sda_oen_o && (state_q == scrb_pkg::ST_IGNORE))
    else $error("Read or foreign address was acknowledged");

  addr_ack_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R19
    (state_q == scrb_pkg::ST_ADDR) && byte_end && (shreg_q == {5'h13, own_addr[1:0], 1'b0})
    && !port_off && !bus_stop && !bus_start |=> !sda_oen_o && (state_q == scrb_pkg::ST_ACK))
    else $error("Own address not acknowledged");

  ratio_commit_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R11
    wr_en && (idx_q == scrb_pkg::IDX_DIV) |=>
    ratio_q == {$past(cfg_q[10][2:0]), $past(shreg_q), $past(cfg_q[12][6])})
    else $error("Divider not committed from stored high bits and parity");

  seq_order_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R24
    wr_en && seq_q && !port_off && !bus_stop && !bus_start |=> idx_q == $past(idx_q) + 4'h1)
    else $error("Sequential index did not advance by one");

  single_pair_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
    wr_en && !seq_q && !port_off && !bus_stop && !bus_start |=> next_q == scrb_pkg::ST_SUB)
    else $error("Single mode data not followed by sub-address");

  keep_cfg_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R15
    !wr_en |=> $stable(cfg_q) && $stable(ratio_q))
    else $error("Register changed without a write");

  cfg_reach_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R14
    launch |-> ##[1:12] (req_q == ack_s2_q))
    else $error("Crossing handshake did not complete");

  hold_pol_a: assert property (@(posedge adc_clk_i) disable iff (!adc_rstn_q) // R04
    $stable(ctrl) ##1 $stable(ctrl) |-> pll_hold_o == ($past(sy_f_q[0]) ^ ctrl[7]))
    else $error("Hold input polarity wrong");

  edge_sel_a: assert property (@(posedge adc_clk_i) disable iff (!adc_rstn_q) // R05
    ref_edge_o && $past(ctrl[5]) |-> $past(ref_prev_q) && !$past(sy_f_q[2]))
    else $error("Reference edge pulse on wrong edge");

  seq_load_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && seq_q && (idx_q == scrb_pkg::IDX_LAST));
  single_write_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && !seq_q && (idx_q == scrb_pkg::IDX_DIV));
  read_refused_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    (state_q == scrb_pkg::ST_ADDR) && byte_end && shreg_q[0]);
  adc_update_c: cover property (@(posedge adc_clk_i) disable iff (!adc_rstn_q)
    req_s2_q != seen_q);

endmodule
`default_nettype wire

/* verification/scrb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-wire bus master, write only
// ----------------------------------------
module scrb_host_model #(
  parameter int Q = 6
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Bus idles released, both lines high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Quarter bit time, moves only after falling clk edges
  task automatic gap();
    repeat (Q) @(negedge clk_i);
  endtask

  // Data falls while the serial clock is high
  task automatic start();
    sda_o = 1'b1;
    scl_o = 1'b1;
    gap();
    sda_o = 1'b0;
    gap();
    scl_o = 1'b0;
    gap();
  endtask

  // One bit: data set while low, line sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    gap();
    scl_o = 1'b1;
    gap();
    r = sda_i;
    gap();
    scl_o = 1'b0;
    gap();
  endtask

  // Byte sent MSB first, ninth clock reads acknowledge (0 = ack)
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask

  // Data rises while the serial clock is high, then bus free time
  task automatic stop();
    sda_o = 1'b0;
    gap();
    scl_o = 1'b1;
    gap();
    sda_o = 1'b1;
    gap();
    gap();
  endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rstn_i, adc_clk_i, scl, sda_h, sda_o, sda_oen_o, sda_w, id1, id2, off, hold, sync, ref_c;
  logic pll_hold_o, line_sync_o, ref_edge_o, praise, plower, csrc, c2en;
  logic [2:0][7:0] clamp;
  logic [2:0][6:0] coarse;
  logic [2:0][4:0] fine;
  logic [2:0] ipsel, zsel;
  logic [1:0] vsel;
  logic [11:0] ratio, exp_ratio;
  logic [4:0] pha, phb;
  logic [7:0] exp_r [14];
  logic [7:0] dev_a;
  int err_total, samples_checked, npulse;
  // Sub-address and data of each single write
  logic [15:0] rows [17] = '{16'h0000, 16'h017F, 16'h021F, 16'h03FF, 16'h0410, 16'h050A, 16'h0680, 16'h0763,
    16'h0801, 16'h09E7, 16'h0A08, 16'h0A10, 16'h0AFF, 16'h0C7F, 16'h0B55, 16'h0D3F, 16'h0E12};

  // ----------------------------------------
  // Clocks, pull-up, design and bus master
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    adc_clk_i = 1'b0;
    #3.7;
    forever #6 adc_clk_i = ~adc_clk_i;
  end
  // Open-drain data wire with pull-up
  assign sda_w = sda_h & (sda_oen_o | sda_o);
  // Counts reference edge pulses in the converter domain
  always @(posedge adc_clk_i)
    if (ref_edge_o === 1'b1)
      npulse <= npulse + 1;

  scrb_top scrb_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .adc_clk_i(adc_clk_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oen_o(sda_oen_o), .bus_id_pin_1_i(id1), .bus_id_pin_2_i(id2),
    .serial_port_off_pin_i(off), .pll_hold_input_i(hold), .line_sync_input_i(sync),
    .line_reference_clock_i(ref_c), .pll_hold_o(pll_hold_o), .line_sync_o(line_sync_o),
    .ref_edge_o(ref_edge_o), .clamp_level_o(clamp), .gain_coarse_o(coarse), .gain_fine_o(fine),
    .pump_force_raise_o(praise), .pump_force_lower_o(plower), .pump_current_select_o(ipsel),
    .loop_filter_resistor_select_o(zsel), .osc_gain_select_o(vsel), .pll_ratio_bits_o(ratio),
    .adc_clock_source_o(csrc), .second_clock_enable_o(c2en), .phase_a_step_o(pha), .phase_b_step_o(phb));
  scrb_host_model scrb_host_model_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));

  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // Expected bank back at power-on values
  task automatic defaults();
    for (int i = 0; i < 14; i++)
      exp_r[i] = scrb_pkg::CFG_RESET[i];
    exp_ratio = scrb_pkg::RATIO_RESET;
  endtask

  // Expected bank update; divider commits on its low byte
  task automatic upd(input logic [7:0] s, input logic [7:0] d);
    if (s[3:0] <= 4'hD)
    begin
      exp_r[s[3:0]] = d;
      if (s[3:0] == 4'hB)
        exp_ratio = {exp_r[10][2:0], d, exp_r[12][6]};
    end
  endtask

  // Let the settings cross, then compare every output field
  task automatic check_all();
    repeat (40) @(negedge clk_i);
    for (int c = 0; c < 3; c++)
    begin
      chk("clamp", {4'h0, exp_r[3*c]}, {4'h0, clamp[c]});
      chk("coarse", {5'h00, exp_r[3*c+1][6:0]}, {5'h00, coarse[c]});
      chk("fine", {7'h00, exp_r[3*c+2][4:0]}, {7'h00, fine[c]});
    end
    chk("force", {10'h000, exp_r[9][4:3]}, {10'h000, praise, plower});
    chk("pump", {9'h000, exp_r[9][2:0]}, {9'h000, ipsel});
    chk("filter", {9'h000, exp_r[10][7:5]}, {9'h000, zsel});
    chk("osc", {10'h000, exp_r[10][4:3]}, {10'h000, vsel});
    chk("ratio", exp_ratio, ratio);
    chk("clksel", {10'h000, exp_r[12][5], exp_r[13][5]}, {10'h000, csrc, c2en});
    chk("phases", {2'h0, exp_r[12][4:0], exp_r[13][4:0]}, {2'h0, pha, phb});
  endtask

  // Hold and sync polarity, reference edge choice; pulses counted from a base
  task automatic pol();
    int n0;
    for (int k = 0; k < 2; k++)
    begin
      {hold, sync} = {~k[0], k[0]};
      n0 = npulse;
      ref_c = 1'b1;
      repeat (20) @(negedge clk_i);
      chk("edge_rise", {11'h000, ~exp_r[9][5]}, 12'(npulse - n0));
      ref_c = 1'b0;
      repeat (20) @(negedge clk_i);
      chk("edge_fall", 12'h001, 12'(npulse - n0));
      chk("hold_sync", {10'h000, ~k[0] ^ exp_r[9][7], k[0] ^ exp_r[9][6]},
        {10'h000, pll_hold_o, line_sync_o});
    end
  endtask

  // Single-register write; a refused address gets no acknowledge
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d, input logic ok);
    logic k;
    scrb_host_model_i.start();
    scrb_host_model_i.tx(a, k);
    chk("addr_ack", {11'h000, ~ok}, {11'h000, k});
    if (ok)
    begin
      scrb_host_model_i.tx(s, k);
      chk("sub_ack", 12'h000, {11'h000, k});
      scrb_host_model_i.tx(d, k);
      chk("data_ack", 12'h000, {11'h000, k});
      upd(s, d);
    end
    scrb_host_model_i.stop();
    check_all();
  endtask

  // Sequential load of n bytes from index 0, test bits kept clear
  task automatic seq(input int n);
    logic k;
    logic [7:0] d;
    scrb_host_model_i.start();
    scrb_host_model_i.tx(dev_a, k);
    scrb_host_model_i.tx(8'h1F, k);
    chk("seq_ack", 12'h000, {11'h000, k});
    for (int i = 0; i < n; i++)
    begin
      d = (i == 9) ? 8'h84 : {i[3:0], ~i[3:0]};
      scrb_host_model_i.tx(d, k);
      chk("seq_ack", 12'h000, {11'h000, k});
      upd({4'h0, i[3:0]} | ((i > 13) ? 8'h0F : 8'h00), d);
    end
    scrb_host_model_i.stop();
    check_all();
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  initial
  begin
    {rstn_i, id1, id2, off, hold, sync, ref_c} = 7'h00;
    err_total = 0;
    samples_checked = 0;
    dev_a = 8'h98;
    defaults();
    repeat (6) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (10) @(negedge clk_i);
    check_all();
    pol();
    foreach (rows[i])
      wr(dev_a, rows[i][15:8], rows[i][7:0], 1'b1);
    pol();
    wr(8'h90, 8'h00, 8'h55, 1'b0);
    wr(dev_a | 8'h01, 8'h00, 8'h55, 1'b0);
    off = 1'b1;
    wr(dev_a, 8'h00, 8'h55, 1'b0);
    off = 1'b0;
    {id2, id1} = 2'b10;
    wr(dev_a, 8'h00, 8'h55, 1'b0);
    dev_a = 8'h9C;
    wr(dev_a, 8'h00, 8'h11, 1'b1);
    rstn_i = 1'b0;
    repeat (6) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (10) @(negedge clk_i);
    defaults();
    check_all();
    seq(15);
    seq(15);
    end_sim();
  end
endmodule
`default_nettype wire
